// *** stc_defs.svh ***
// Constants, codes and timing counts of the self-test mode controller
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
`define STC_OP_SEND_DIAG   8'h1D
`define STC_OP_INQUIRY     8'h12
`define STC_OP_REPORT_LUNS 8'hA0
`define STC_OP_REQ_SENSE   8'h03
`define STC_OP_WRITE_BUF   8'h3B
`define STC_OP_FORMAT      8'h04
`define STC_OP_START_STOP  8'h1B
`define STC_WB_DL_LO       5'h04
`define STC_WB_DL_HI       5'h07
`define STC_WB_DL_E        5'h0E
`define STC_WB_DL_F        5'h0F
`define STC_CODE_DEFAULT   3'h0
`define STC_CODE_BG_SHORT  3'h1
`define STC_CODE_BG_EXT    3'h2
`define STC_CODE_ABORT     3'h4
`define STC_CODE_FG_SHORT  3'h5
`define STC_CODE_FG_EXT    3'h6
`define STC_STAT_GOOD      8'h00
`define STC_STAT_CHECK     8'h02
`define STC_KEY_NOT_READY  4'h2
`define STC_KEY_HW_ERROR   4'h4
`define STC_ASC_NOT_READY  8'h04
`define STC_ASCQ_IN_PROG   8'h09
`define STC_ASC_FAILED     8'h3E
`define STC_ASCQ_FAILED    8'h03
`define STC_ASCQ_NO_LOG    8'h04
`define STC_RES_PASS       4'h0
`define STC_RES_ABORT_CMD  4'h1
`define STC_RES_ABORT_EXC  4'h2
`define STC_RES_FAIL       4'h3
`define STC_RES_RUNNING    4'hF
`define STC_LAST_SEG       2'h3
`define STC_LOG_DEPTH      20
`define STC_LOG_LAST       5'h13
`define STC_LOG_FULL       5'h14
`define STC_CLK_HZ         64'h0131_2D00
`define STC_SUSP_MAX_S     64'h0002
`define STC_SHORT_MAX_MIN  64'h0002
`define STC_SUSP_CYC       (`STC_SUSP_MAX_S * `STC_CLK_HZ)
`define STC_SHORT_CYC      (`STC_SHORT_MAX_MIN * 64'h003C * `STC_CLK_HZ)
`endif

// *** stc_pkg.sv ***
// Types shared by the self-test mode controller
`include "stc_defs.svh"
package stc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_FG, ST_BG_INIT, ST_BG, ST_BG_SUSP, ST_BG_SERVE, ST_BG_ABORT
   } stc_mode_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic       st_bit;
      logic [2:0] st_code;
      logic [4:0] wb_mode;
      logic       start;
   } stc_cmd_t;
   typedef struct packed {
      logic [7:0]  status;
      logic [3:0]  key;
      logic [7:0]  asc;
      logic [7:0]  ascq;
      logic        sks_valid;
      logic [15:0] progress;
   } stc_rsp_t;
   typedef struct packed {
      logic [2:0] code;
      logic [3:0] result;
   } stc_log_t;
   typedef struct packed {
      stc_mode_t                     mode;
      logic [1:0]                    seg_idx;
      logic                          seg_go;
      logic                          is_short;
      logic [2:0]                    st_code;
      logic                          ev_done;
      logic                          ev_fail;
      stc_cmd_t                      pend;
      logic [31:0]                   tmr;
      logic [31:0]                   run_tmr;
      logic [4:0]                    wp;
      logic [4:0]                    count;
      stc_log_t [`STC_LOG_DEPTH-1:0] log;
      logic                          rsp_valid;
      stc_rsp_t                      rsp;
      logic                          cmd_pass;
      logic                          cmd_rdy;
      logic [1:0]                    act;
      stc_log_t                      log_rd;
   } stc_state_t;
endpackage : stc_pkg

// *** stc_self_test_ctrl.sv ***
// Self-test mode controller: launch, refusal, suspension, abort and results log
`timescale 1ns/1ps
`include "stc_defs.svh"
module stc_self_test_ctrl #(
   parameter logic [31:0] SUSP_CYC  = 32'(`STC_SUSP_CYC),
   parameter logic [31:0] SHORT_CYC = 32'(`STC_SHORT_CYC)
) (
   input  wire logic             clk,         // 20 MHz clock
   input  wire logic             resetn,      // Async reset, active low
   input  wire logic             cmd_valid,   // Decoded command present
   input  wire stc_pkg::stc_cmd_t cmd,        // Decoded command fields
   input  wire logic             tmf_abort,   // Abort task / set / clear set
   input  wire logic             svc_done,    // Passed command finished
   input  wire logic             seg_done,    // Segment finished, pulse
   input  wire logic             seg_fail,    // Segment failed, pulse
   input  wire logic             seg_busy,    // Segment engine still active
   input  wire logic             log_fail,    // Log storage unwritable
   input  wire logic [4:0]       log_rd_idx,  // Results log read slot
   output logic                  cmd_rdy,     // Command can be taken
   output logic                  rsp_valid,   // Status answer, pulse
   output stc_pkg::stc_rsp_t     rsp,         // Status and sense data
   output logic                  cmd_pass,    // Hand command on, pulse
   output stc_pkg::stc_cmd_t     pass_cmd,    // Command handed on
   output logic                  seg_go,      // Run current segment
   output logic [1:0]            seg_idx,     // Current segment number
   output logic [1:0]            test_act,    // 0 idle, 1 fg, 2 bg
   output logic [4:0]            log_wp,      // Next log slot
   output logic [4:0]            log_count,   // Valid log entries
   output stc_pkg::stc_log_t     log_rd       // Log slot contents
);
   stc_pkg::stc_state_t s;
   stc_pkg::stc_state_t n;
   logic                take;
   logic                busy_step;

   // Status and sense record builder
   function automatic stc_pkg::stc_rsp_t mk(logic [7:0] st, logic [3:0] k, logic [7:0] a,
                                             logic [7:0] q, logic sv, logic [1:0] idx);
      stc_pkg::stc_rsp_t r;
      r.status    = st;
      r.key       = k;
      r.asc       = a;
      r.ascq      = q;
      r.sks_valid = sv;
      r.progress  = {idx, 14'h0000};
      return r;
   endfunction : mk

   // Commands that end a background test instead of suspending it
   function automatic logic is_exc(stc_pkg::stc_cmd_t c);
      logic dl;
      dl = (c.wb_mode >= `STC_WB_DL_LO && c.wb_mode <= `STC_WB_DL_HI)
           || c.wb_mode == `STC_WB_DL_E || c.wb_mode == `STC_WB_DL_F;
      return (c.opcode == `STC_OP_SEND_DIAG && c.st_code == `STC_CODE_ABORT)
             || (c.opcode == `STC_OP_WRITE_BUF && dl)
             || c.opcode == `STC_OP_FORMAT
             || (c.opcode == `STC_OP_START_STOP && !c.start);
   endfunction : is_exc

   // End of a test: write result and advance the ring unless log storage fails, back to idle
   function automatic stc_pkg::stc_state_t fin(stc_pkg::stc_state_t x, logic [3:0] res,
                                                logic lf);
      x.mode    = stc_pkg::ST_IDLE;
      x.seg_go  = 1'b0;
      x.ev_done = 1'b0;
      x.ev_fail = 1'b0;
      x.run_tmr = 32'h0000_0000;
      if (!lf) begin
         x.log[x.wp] = {x.st_code, res};
         x.wp        = (x.wp == `STC_LOG_LAST) ? 5'h00 : x.wp + 5'h01;
         if (x.count != `STC_LOG_FULL) begin
            x.count = x.count + 5'h01;
         end
      end
      return x;
   endfunction : fin

   assign take = cmd_valid && s.cmd_rdy;

   // Next-state logic for the whole controller
   always_comb begin
      n           = s;
      busy_step   = 1'b0;
      n.rsp_valid = 1'b0;
      n.cmd_pass  = 1'b0;
      n.log_rd    = (log_rd_idx < `STC_LOG_LAST + 5'h01) ? s.log[log_rd_idx] : '0;
      // Segment pulses are sticky so a busy cycle never loses one
      if (seg_done) begin
         n.ev_done = 1'b1;
      end
      if (seg_fail) begin
         n.ev_fail = 1'b1;
      end
      if (s.is_short && (s.mode == stc_pkg::ST_FG || s.mode == stc_pkg::ST_BG
                         || s.mode == stc_pkg::ST_BG_SUSP || s.mode == stc_pkg::ST_BG_SERVE)) begin
         n.run_tmr = s.run_tmr + 32'h0000_0001;
         if (s.run_tmr >= SHORT_CYC - 32'h0000_0001) begin
            n.ev_fail = 1'b1;
         end
      end
      case (s.mode)
         stc_pkg::ST_IDLE: begin
            if (take && cmd.opcode == `STC_OP_SEND_DIAG && !cmd.st_bit
                && (cmd.st_code == `STC_CODE_BG_SHORT || cmd.st_code == `STC_CODE_BG_EXT)) begin
               n.rsp_valid = 1'b1;
               n.rsp       = mk(`STC_STAT_GOOD, 4'h0, 8'h00, 8'h00, 1'b0, 2'h0);
               n.mode      = stc_pkg::ST_BG_INIT;
               n.st_code   = cmd.st_code;
               n.is_short  = cmd.st_code == `STC_CODE_BG_SHORT;
               n.seg_idx   = 2'h0;
               n.run_tmr   = 32'h0000_0000;
            end else if (take && cmd.opcode == `STC_OP_SEND_DIAG && !cmd.st_bit
                && (cmd.st_code == `STC_CODE_FG_SHORT || cmd.st_code == `STC_CODE_FG_EXT)) begin
               // no status yet, answer comes at the end
               n.mode     = stc_pkg::ST_FG;
               n.st_code  = cmd.st_code;
               n.is_short = cmd.st_code == `STC_CODE_FG_SHORT;
               n.seg_idx  = 2'h0;
               n.seg_go   = 1'b1;
               n.run_tmr  = 32'h0000_0000;
            end else if (take) begin
               n.cmd_pass = 1'b1;
               n.pend     = cmd;
            end
         end
         stc_pkg::ST_BG_INIT: begin
            n.log[s.wp] = {s.st_code, `STC_RES_RUNNING};
            n.mode      = stc_pkg::ST_BG;
            n.seg_go    = 1'b1;
         end
         stc_pkg::ST_FG: begin
            if (tmf_abort) begin
               n = fin(n, `STC_RES_ABORT_EXC, log_fail);
            end else if (take && (cmd.opcode == `STC_OP_INQUIRY
                                  || cmd.opcode == `STC_OP_REPORT_LUNS)) begin
               n.cmd_pass = 1'b1;
               n.pend     = cmd;
            end else if (take) begin
               n.rsp_valid = 1'b1;
               n.rsp = mk(cmd.opcode == `STC_OP_REQ_SENSE ? `STC_STAT_GOOD : `STC_STAT_CHECK,
                          `STC_KEY_NOT_READY, `STC_ASC_NOT_READY, `STC_ASCQ_IN_PROG,
                          cmd.opcode == `STC_OP_REQ_SENSE, s.seg_idx);
            end else begin
               busy_step = 1'b1;
            end
         end
         stc_pkg::ST_BG: begin
            if (take && cmd.opcode == `STC_OP_SEND_DIAG && (cmd.st_bit
                || (cmd.st_code != `STC_CODE_DEFAULT && cmd.st_code != `STC_CODE_ABORT))) begin
               n.rsp_valid = 1'b1;
               n.rsp = mk(`STC_STAT_CHECK, `STC_KEY_NOT_READY, `STC_ASC_NOT_READY,
                          `STC_ASCQ_IN_PROG, 1'b0, s.seg_idx);
            end else if (take && cmd.opcode == `STC_OP_REQ_SENSE) begin
               n.rsp_valid = 1'b1;
               n.rsp = mk(`STC_STAT_GOOD, `STC_KEY_NOT_READY, `STC_ASC_NOT_READY,
                          `STC_ASCQ_IN_PROG, 1'b1, s.seg_idx);
            end else if (take) begin
               // stop the engine, then serve or abort
               n.pend   = cmd;
               n.seg_go = 1'b0;
               n.tmr    = 32'h0000_0000;
               n.mode   = is_exc(cmd) ? stc_pkg::ST_BG_ABORT : stc_pkg::ST_BG_SUSP;
            end else begin
               busy_step = 1'b1;
            end
         end
         stc_pkg::ST_BG_SUSP: begin
            n.tmr = s.tmr + 32'h0000_0001;
            // serve once stopped, or when the bound runs out
            if (!seg_busy || s.tmr >= SUSP_CYC - 32'h0000_0002) begin
               n.cmd_pass = 1'b1;
               n.mode     = stc_pkg::ST_BG_SERVE;
            end
         end
         stc_pkg::ST_BG_SERVE: begin
            if (svc_done) begin
               n.mode   = stc_pkg::ST_BG;
               n.seg_go = 1'b1;
            end
         end
         stc_pkg::ST_BG_ABORT: begin
            n.tmr = s.tmr + 32'h0000_0001;
            if (!seg_busy || s.tmr >= SUSP_CYC - 32'h0000_0002) begin
               // log the abort and serve or answer in the same cycle
               if (s.pend.opcode == `STC_OP_SEND_DIAG) begin
                  n           = fin(n, `STC_RES_ABORT_CMD, log_fail);
                  n.rsp_valid = 1'b1;
                  n.rsp       = mk(`STC_STAT_GOOD, 4'h0, 8'h00, 8'h00, 1'b0, 2'h0);
               end else begin
                  n          = fin(n, `STC_RES_ABORT_EXC, log_fail);
                  n.cmd_pass = 1'b1;
               end
            end
         end
         default: begin
            n.mode = stc_pkg::ST_IDLE;
         end
      endcase
      // Segment sequencing in either running mode
      if (busy_step && s.ev_fail) begin
         n = fin(n, `STC_RES_FAIL, log_fail);
         if (s.mode == stc_pkg::ST_FG) begin
            n.rsp_valid = 1'b1;
            n.rsp = mk(`STC_STAT_CHECK, `STC_KEY_HW_ERROR, `STC_ASC_FAILED,
                       log_fail ? `STC_ASCQ_NO_LOG : `STC_ASCQ_FAILED, 1'b0, s.seg_idx);
         end
      end else if (busy_step && s.ev_done && s.seg_idx == `STC_LAST_SEG) begin
         n = fin(n, `STC_RES_PASS, log_fail);
         if (s.mode == stc_pkg::ST_FG) begin
            n.rsp_valid = 1'b1;
            n.rsp = mk(log_fail ? `STC_STAT_CHECK : `STC_STAT_GOOD,
                       log_fail ? `STC_KEY_HW_ERROR : 4'h0,
                       log_fail ? `STC_ASC_FAILED : 8'h00,
                       log_fail ? `STC_ASCQ_NO_LOG : 8'h00, 1'b0, 2'h0);
         end
      end else if (busy_step && s.ev_done) begin
         n.seg_idx = s.seg_idx + 2'h1;
         n.ev_done = seg_done;
      end
      // one test at a time, ready only in settled modes
      n.cmd_rdy = n.mode == stc_pkg::ST_IDLE || n.mode == stc_pkg::ST_FG
                  || n.mode == stc_pkg::ST_BG;
      n.act = (n.mode == stc_pkg::ST_IDLE) ? 2'h0 : (n.mode == stc_pkg::ST_FG) ? 2'h1 : 2'h2;
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s         <= '0;
         s.mode    <= stc_pkg::ST_IDLE;
         s.cmd_rdy <= 1'b1;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register
   assign cmd_rdy   = s.cmd_rdy;
   assign rsp_valid = s.rsp_valid;
   assign rsp       = s.rsp;
   assign cmd_pass  = s.cmd_pass;
   assign pass_cmd  = s.pend;
   assign seg_go    = s.seg_go;
   assign seg_idx   = s.seg_idx;
   assign test_act  = s.act;
   assign log_wp    = s.wp;
   assign log_count = s.count;
   assign log_rd    = s.log_rd;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence bg_launch;
      s.mode == stc_pkg::ST_IDLE && take && cmd.opcode == `STC_OP_SEND_DIAG && !cmd.st_bit
      && cmd.st_code == `STC_CODE_BG_SHORT;
   endsequence
   sequence bg_start_steps;
      rsp_valid && rsp.status == `STC_STAT_GOOD && !seg_go
      ##1 s.log[$past(s.wp, 2)].result == `STC_RES_RUNNING && seg_go;
   endsequence

   // no foreground status while segments remain
   a_fg_status_hold: assert property (s.mode == stc_pkg::ST_FG && !tmf_abort && !s.ev_fail
      && !s.ev_done && !take |=> !rsp_valid) else $error("foreground status too early");
   // foreground refusal of all but the three
   a_fg_reject: assert property (s.mode == stc_pkg::ST_FG && !tmf_abort && take
      && cmd.opcode != `STC_OP_INQUIRY && cmd.opcode != `STC_OP_REPORT_LUNS
      && cmd.opcode != `STC_OP_REQ_SENSE |=> rsp_valid && rsp.status == `STC_STAT_CHECK
      && rsp.key == `STC_KEY_NOT_READY) else $error("foreground command not refused");
   a_fg_fail_sense: assert property (s.mode == stc_pkg::ST_FG && s.ev_fail && !take
      && !tmf_abort |=> rsp_valid && rsp.key == `STC_KEY_HW_ERROR
      && rsp.ascq == ($past(log_fail) ? `STC_ASCQ_NO_LOG : `STC_ASCQ_FAILED))
      else $error("foreground failure sense wrong");
   // task abort ends test and logs
   a_tmf_abort: assert property (s.mode == stc_pkg::ST_FG && tmf_abort && !log_fail
      |=> test_act == 2'h0 && !rsp_valid && log_wp != $past(log_wp))
      else $error("task abort not honoured");
   // background status, then log init and segment start together
   a_bg_start: assert property (bg_launch |=> bg_start_steps)
      else $error("background start order wrong");
   a_bg_reject: assert property (s.mode == stc_pkg::ST_BG && take
      && cmd.opcode == `STC_OP_SEND_DIAG && cmd.st_bit |=> rsp_valid
      && rsp.status == `STC_STAT_CHECK && s.mode == stc_pkg::ST_BG)
      else $error("background launch not refused");
   a_susp_bound: assert property (s.mode == stc_pkg::ST_BG_SUSP |-> s.tmr < SUSP_CYC)
      else $error("suspension too long");
   // exception abort finishes once engine stops
   a_exc_abort: assert property (s.mode == stc_pkg::ST_BG_ABORT && !seg_busy
      |=> test_act == 2'h0 && (cmd_pass || rsp_valid)) else $error("exception abort stalled");
   a_sense_prog: assert property (s.mode == stc_pkg::ST_BG && take
      && cmd.opcode == `STC_OP_REQ_SENSE |=> rsp.sks_valid && rsp.asc == `STC_ASC_NOT_READY
      && rsp.progress[15:14] == $past(seg_idx)) else $error("sense progress wrong");
   a_log_single: assert property (log_count <= `STC_LOG_FULL
      && (seg_go -> test_act != 2'h0)) else $error("log or activity state wrong");
endmodule : stc_self_test_ctrl

// *** stc_seg_model.sv ***
// Segment engine model standing behind the self-test controller
`timescale 1ns/1ps
module stc_seg_model (
   input  wire logic       clk,      // Shared clock
   input  wire logic       resetn,   // Async reset, active low
   input  wire logic       seg_go,   // Run request
   input  wire logic [1:0] seg_idx,  // Segment asked for
   input  wire logic [9:0] dly,      // Cycles per segment, less one
   input  wire logic [2:0] fail_seg, // Bit 2 arms a failure on segment [1:0]
   output logic            seg_done, // Segment finished, pulse
   output logic            seg_fail, // Segment failed, pulse
   output logic            seg_busy  // Engine active
);
   logic [9:0] cnt;
   // Busy trails go by a cycle, so a suspension is never instant
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 10'h000;
         seg_done <= 1'b0;
         seg_fail <= 1'b0;
         seg_busy <= 1'b0;
      end else begin
         seg_busy <= seg_go;
         seg_done <= 1'b0;
         seg_fail <= 1'b0;
         if (!seg_go) begin
            cnt <= 10'h000;
         end else if (cnt == dly) begin
            cnt <= 10'h000;
            seg_fail <= fail_seg[2] && (fail_seg[1:0] == seg_idx);
            seg_done <= !(fail_seg[2] && (fail_seg[1:0] == seg_idx));
         end else begin
            cnt <= cnt + 10'h001;
         end
      end
   end
endmodule : stc_seg_model

// *** tb_self_test_mode_controller.sv ***
// Self-checking bench for the self-test mode controller
`timescale 1ns/1ps
`include "stc_defs.svh"
module tb_self_test_mode_controller;
   logic clk, resetn, cmd_valid, tmf_abort, svc_done, log_fail;
   logic seg_done, seg_fail, seg_busy, cmd_rdy, rsp_valid, cmd_pass, seg_go;
   logic [4:0] log_rd_idx, log_wp, log_count, ewp;
   logic [1:0] seg_idx, test_act;
   logic [9:0] dly;
   logic [2:0] fail_seg;
   stc_pkg::stc_cmd_t cmd, pass_cmd;
   stc_pkg::stc_rsp_t rsp;
   stc_pkg::stc_log_t log_rd;
   int mismatches, tests_run;
   stc_self_test_ctrl #(.SUSP_CYC(32'h0000_0014), .SHORT_CYC(32'h0000_01F4)) i_stc_self_test_ctrl (
      .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd), .tmf_abort(tmf_abort),
      .svc_done(svc_done), .seg_done(seg_done), .seg_fail(seg_fail), .seg_busy(seg_busy),
      .log_fail(log_fail), .log_rd_idx(log_rd_idx), .cmd_rdy(cmd_rdy), .rsp_valid(rsp_valid),
      .rsp(rsp), .cmd_pass(cmd_pass), .pass_cmd(pass_cmd), .seg_go(seg_go), .seg_idx(seg_idx),
      .test_act(test_act), .log_wp(log_wp), .log_count(log_count), .log_rd(log_rd));
   stc_seg_model i_stc_seg_model (
      .clk(clk), .resetn(resetn), .seg_go(seg_go), .seg_idx(seg_idx), .dly(dly),
      .fail_seg(fail_seg), .seg_done(seg_done), .seg_fail(seg_fail), .seg_busy(seg_busy));
   // 50 ns period
   always #25 clk = ~clk;
   task automatic print_verdict;
      $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_rsp(input logic [7:0] s, input logic [3:0] k, input logic [7:0] a, q);
      chk_val(32'({rsp.status, rsp.key, rsp.asc, rsp.ascq}), 32'({s, k, a, q}));
   endtask : chk_rsp
   task automatic chk_log(input logic [2:0] c, input logic [3:0] r);
      @(posedge clk);
      log_rd_idx <= ewp;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk_val(32'(log_rd), 32'({c, r}));
      ewp = (ewp == `STC_LOG_LAST) ? 5'h00 : ewp + 5'h01;
   endtask : chk_log
   // Sel 0 answer, 1 hand-on, 2 idle; a spent bound ends the run
   task automatic wait_ev(input int sel, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(negedge clk);
         if ((sel == 0 && rsp_valid === 1'b1) || (sel == 1 && cmd_pass === 1'b1)) break;
         if (sel == 2 && test_act === 2'h0) break;
      end
      if (i == n) begin
         mismatches++;
         print_verdict;
      end
   endtask : wait_ev
   function automatic stc_pkg::stc_cmd_t mk(input logic [7:0] op, input logic sb,
                                            input logic [2:0] sc, input logic [4:0] wm);
      mk = {op, sb, sc, wm, 1'b0};
   endfunction : mk
   // Command held until an edge that samples ready high; ready settles by the falling edge
   task automatic send(input stc_pkg::stc_cmd_t c);
      int i;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= c;
      for (i = 0; i < 50; i++) begin
         @(negedge clk);
         if (cmd_rdy === 1'b1) break;
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      if (i == 50) begin
         mismatches++;
         print_verdict;
      end
   endtask : send
   task automatic cfg(input logic [9:0] d, input logic [2:0] f, input logic lf);
      @(posedge clk);
      dly <= d;
      fail_seg <= f;
      log_fail <= lf;
   endtask : cfg
   task automatic t_fg_pass;
      realtime t0;
      cfg(10'h01E, 3'h0, 1'b0);
      t0 = $realtime;
      send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_FG_SHORT, 5'h00));
      @(negedge clk);
      chk_val(32'(test_act), 32'h0000_0001);
      send(mk(8'h28, 1'b0, 3'h0, 5'h00));
      wait_ev(0, 3);
      chk_rsp(`STC_STAT_CHECK, `STC_KEY_NOT_READY, `STC_ASC_NOT_READY, `STC_ASCQ_IN_PROG);
      send(mk(`STC_OP_INQUIRY, 1'b0, 3'h0, 5'h00));
      wait_ev(1, 3);
      chk_val(32'(pass_cmd.opcode), 32'(`STC_OP_INQUIRY));
      send(mk(`STC_OP_REPORT_LUNS, 1'b0, 3'h0, 5'h00));
      wait_ev(1, 3);
      chk_val(32'(pass_cmd.opcode), 32'(`STC_OP_REPORT_LUNS));
      send(mk(`STC_OP_REQ_SENSE, 1'b0, 3'h0, 5'h00));
      wait_ev(0, 3);
      chk_rsp(`STC_STAT_GOOD, `STC_KEY_NOT_READY, `STC_ASC_NOT_READY, `STC_ASCQ_IN_PROG);
      chk_val(32'(rsp.sks_valid), 32'h0000_0001);
      wait_ev(0, 400);
      chk_val(32'(rsp.status), 32'(`STC_STAT_GOOD));
      chk_val(32'($realtime - t0 >= 6000.0), 32'h0000_0001);
      chk_log(`STC_CODE_FG_SHORT, `STC_RES_PASS);
   endtask : t_fg_pass
   task automatic t_fg_fail;
      cfg(10'h01E, 3'h5, 1'b0);
      send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_FG_EXT, 5'h00));
      wait_ev(0, 400);
      chk_rsp(`STC_STAT_CHECK, `STC_KEY_HW_ERROR, `STC_ASC_FAILED, `STC_ASCQ_FAILED);
      chk_log(`STC_CODE_FG_EXT, `STC_RES_FAIL);
      cfg(10'h01E, 3'h4, 1'b1);
      send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_FG_SHORT, 5'h00));
      wait_ev(0, 400);
      chk_rsp(`STC_STAT_CHECK, `STC_KEY_HW_ERROR, `STC_ASC_FAILED, `STC_ASCQ_NO_LOG);
      chk_val(32'(log_wp), 32'(ewp));
      // Segments slower than the short limit must end as a failure
      cfg(10'h3E8, 3'h0, 1'b0);
      send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_FG_SHORT, 5'h00));
      wait_ev(0, 800);
      chk_rsp(`STC_STAT_CHECK, `STC_KEY_HW_ERROR, `STC_ASC_FAILED, `STC_ASCQ_FAILED);
      chk_log(`STC_CODE_FG_SHORT, `STC_RES_FAIL);
      cfg(10'h01E, 3'h0, 1'b0);
      send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_FG_SHORT, 5'h00));
      repeat (10) @(posedge clk);
      tmf_abort <= 1'b1;
      @(posedge clk);
      tmf_abort <= 1'b0;
      wait_ev(2, 3);
      chk_log(`STC_CODE_FG_SHORT, `STC_RES_ABORT_EXC);
   endtask : t_fg_fail
   task automatic t_bg_run;
      send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_BG_SHORT, 5'h00));
      wait_ev(0, 2);
      chk_val(32'(rsp.status), 32'(`STC_STAT_GOOD));
      chk_log(`STC_CODE_BG_SHORT, `STC_RES_RUNNING);
      ewp = (ewp == 5'h00) ? `STC_LOG_LAST : ewp - 5'h01;
      chk_val(32'(test_act), 32'h0000_0002);
      send(mk(`STC_OP_SEND_DIAG, 1'b1, 3'h0, 5'h00));
      wait_ev(0, 3);
      chk_rsp(`STC_STAT_CHECK, `STC_KEY_NOT_READY, `STC_ASC_NOT_READY, `STC_ASCQ_IN_PROG);
      for (int c = 1; c < 8; c++) begin
         if (c != 4) begin
            send(mk(`STC_OP_SEND_DIAG, 1'b0, 3'(c), 5'h00));
            wait_ev(0, 3);
            chk_val(32'(rsp.status), 32'(`STC_STAT_CHECK));
         end
      end
      send(mk(`STC_OP_REQ_SENSE, 1'b0, 3'h0, 5'h00));
      wait_ev(0, 3);
      chk_rsp(`STC_STAT_GOOD, `STC_KEY_NOT_READY, `STC_ASC_NOT_READY, `STC_ASCQ_IN_PROG);
      chk_val(32'({rsp.sks_valid, test_act}), 32'h0000_0006);
      send(mk(8'h28, 1'b0, 3'h0, 5'h00));
      wait_ev(1, 30);
      chk_val(32'(pass_cmd.opcode), 32'h0000_0028);
      chk_val(32'({seg_go, cmd_rdy}), 32'h0000_0000);
      @(posedge clk);
      svc_done <= 1'b1;
      @(posedge clk);
      svc_done <= 1'b0;
      @(negedge clk);
      chk_val(32'({seg_go, cmd_rdy, test_act}), 32'h0000_000E);
      wait_ev(2, 400);
      chk_log(`STC_CODE_BG_SHORT, `STC_RES_PASS);
      // Background failure shows only in the log, never in status
      cfg(10'h01E, 3'h6, 1'b0);
      send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_BG_EXT, 5'h00));
      wait_ev(2, 400);
      chk_val(32'(rsp.status), 32'(`STC_STAT_GOOD));
      chk_log(`STC_CODE_BG_EXT, `STC_RES_FAIL);
      cfg(10'h01E, 3'h0, 1'b0);
   endtask : t_bg_run
   task automatic t_bg_abort;
      stc_pkg::stc_cmd_t ex [3];
      ex[0] = mk(`STC_OP_FORMAT, 1'b0, 3'h0, 5'h00);
      ex[1] = mk(`STC_OP_START_STOP, 1'b0, 3'h0, 5'h00);
      ex[2] = mk(`STC_OP_WRITE_BUF, 1'b0, 3'h0, 5'h05);
      for (int i = 0; i < 23; i++) begin
         send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_BG_EXT, 5'h00));
         wait_ev(0, 2);
         if (i < 3) begin
            send(ex[i]);
            wait_ev(1, 30);
            chk_val(32'(pass_cmd), 32'(ex[i]));
            wait_ev(2, 5);
            chk_log(`STC_CODE_BG_EXT, `STC_RES_ABORT_EXC);
         end else begin
            send(mk(`STC_OP_SEND_DIAG, 1'b0, `STC_CODE_ABORT, 5'h00));
            wait_ev(0, 30);
            chk_val(32'(rsp.status), 32'(`STC_STAT_GOOD));
            wait_ev(2, 5);
            chk_log(`STC_CODE_BG_EXT, `STC_RES_ABORT_CMD);
         end
      end
      chk_val(32'(log_count), 32'(`STC_LOG_FULL));
      chk_val(32'(log_wp), 32'(ewp));
   endtask : t_bg_abort
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      {cmd_valid, tmf_abort, svc_done, log_fail} = 4'h0;
      cmd = '0;
      log_rd_idx = 5'h00;
      dly = 10'h01E;
      fail_seg = 3'h0;
      ewp = 5'h00;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk_val(32'({cmd_rdy, test_act, log_count, log_wp, rsp_valid, cmd_pass}), 32'h0000_4000);
      t_fg_pass;
      t_fg_fail;
      t_bg_run;
      t_bg_abort;
      print_verdict;
   end
endmodule : tb_self_test_mode_controller
